// *** core/addr_map_pkg.sv ***
// Constants and types shared by the address-space decoder
package addr_map_pkg;

  // ---------------------------------------------------------------
  // Program memory
  // ---------------------------------------------------------------
  localparam int PROG_ADDR_W = 16;
  localparam int ROM_ADDR_W = 14;
  localparam int ROM_DEPTH = 16384;
  localparam logic [15:0] ROM_LAST = 16'h3FFF;
  localparam logic [15:0] VECTOR_LAST = 16'h00FF;
  localparam logic [15:0] RESET_PC = 16'h0100;
  localparam logic [15:0] OPTION_FIRST = 16'h003C;
  localparam logic [15:0] OPTION_LAST = 16'h003F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [31:0] OPTION_RESET = 32'hFFFF_FFFF;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  localparam int REG_ADDR_W = 8;
  localparam int REG_IDX_W = 10;
  localparam int REG_MEM_DEPTH = 1024;
  localparam logic [7:0] SET1_FIRST = 8'hC0;
  localparam logic [7:0] BANKED_FIRST = 8'hE0;
  localparam logic [3:0] WORKING_NIBBLE = 4'hC;
  localparam logic [7:0] SLICE_A_ADDR = 8'hD6;
  localparam logic [7:0] SLICE_B_ADDR = 8'hD7;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'hDF;
  localparam logic [7:0] SLICE_A_RESET = 8'hC0;
  localparam logic [7:0] SLICE_B_RESET = 8'hC8;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
  localparam logic [3:0] PAGE_COUNT = 4'h2;
  localparam int PAGE_SRC_LSB = 0;
  localparam int PAGE_DST_LSB = 4;
  localparam int SLICE_LSB = 3;
  localparam logic [3:0] SECOND_SLICE_LOW = 4'h8;
  // Physical region tags, top two bits of a storage index
  localparam logic [1:0] REGION_SET2 = 2'h2;
  localparam logic [1:0] REGION_SET1 = 2'h3;

  typedef enum logic [1:0] {
    mode_direct,
    mode_indirect,
    mode_working
  } addr_mode_t;

  typedef enum logic [1:0] {
    tgt_mem,
    tgt_slice_a,
    tgt_slice_b,
    tgt_page
  } target_t;

  typedef struct packed {
    logic [REG_IDX_W-1:0] idx;
    target_t target;
    logic err;
  } decode_t;

endpackage

// *** core/register_file_address_map.sv ***
// Program memory and paged register file address decoder
//
// Behaviour
// - 16-bit program bus, separate 8-bit register bus
// - Program memory decodes 0000 to 3FFF
// - Vector area 00-FF still fetchable as code
// - Fetch starts at 0100 after reset
// - Option bytes 003C-003F; erased reads FF
// - Two register pages via select at DF
// - Low nibble source page, high destination
// - Set 1 occupies C0 to FF
// - Set 1 decoding ignores page select
// - E0-FF banked for direct access, working access uses bank 0; reset selects bank 0
// - D0-DF system, C0-CF common working area
// - C0-CF reached only by working addressing
// - Direct selects set 1; indirect selects set 2
// - Set 2 follows page select
// - Prime area 00-BF paged, page 0 at reset
// - Slice pointers pick 8-byte slices by bits 7:3
// - Slice pointers at D6, D7; load or set
// - Reset pointers to C0 and C8
// - Working addressing never reaches set 2
// - Combined set loads op high nibble with low 0 and with low 8
// - Bit 3 picks pointer, concatenate high bits
// - Upper nibble 1100 means working address in direct mode; indirect C0-CF goes to set 2
// - Register pair: even MSB, odd LSB
module register_file_address_map (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic fetch_en,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_addr,
  input wire logic rom_load_en,
  input wire logic [15:0] rom_load_addr,
  input wire logic [7:0] rom_load_data,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_pair,
  input wire logic [7:0] reg_addr,
  input wire addr_map_pkg::addr_mode_t reg_mode,
  input wire logic [15:0] reg_wdata,
  input wire logic select_bank_zero_instr,
  input wire logic select_bank_one_instr,
  input wire logic set_both_slice_pointers_instr,
  input wire logic set_first_slice_pointer_instr,
  input wire logic set_second_slice_pointer_instr,
  input wire logic [7:0] slice_operand,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_rdata,
  output logic prog_rvalid,
  output logic prog_vector_area,
  output logic prog_option_area,
  output logic prog_range_err,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_access_err,
  output logic [7:0] working_slice_pointer_a,
  output logic [7:0] working_slice_pointer_b,
  output logic [7:0] register_page_select,
  output logic bank_select
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] prog_rdata;
    logic prog_rvalid;
    logic prog_vector;
    logic prog_option;
    logic prog_range_err;
    logic [31:0] option_bytes;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic reg_access_err;
    logic [7:0] slice_a;
    logic [7:0] slice_b;
    logic [7:0] page_sel;
    logic bank;
  } state_t;

  localparam state_t STATE_RESET = '{
    pc: addr_map_pkg::RESET_PC,
    prog_rdata: 8'h00,
    prog_rvalid: 1'b0,
    prog_vector: 1'b0,
    prog_option: 1'b0,
    prog_range_err: 1'b0,
    option_bytes: addr_map_pkg::OPTION_RESET,
    reg_rdata: 16'h0000,
    reg_rvalid: 1'b0,
    reg_access_err: 1'b0,
    slice_a: addr_map_pkg::SLICE_A_RESET,
    slice_b: addr_map_pkg::SLICE_B_RESET,
    page_sel: addr_map_pkg::PAGE_SELECT_RESET,
    bank: 1'b0
  };

  state_t state;
  state_t next_state;

  // Storage arrays are left unreset; only control state is cleared
  logic [7:0] rom_mem [addr_map_pkg::ROM_DEPTH];
  logic [7:0] reg_mem [addr_map_pkg::REG_MEM_DEPTH];

  // ---------------------------------------------------------------
  // Decoding functions
  // ---------------------------------------------------------------
  function automatic addr_map_pkg::decode_t decode_reg(
    input logic [7:0] a,
    input addr_map_pkg::addr_mode_t m,
    input logic [3:0] page,
    input logic bank,
    input logic [7:0] spa,
    input logic [7:0] spb
  );
    addr_map_pkg::decode_t d;
    logic [7:0] eff;
    logic working;
    logic bank_bit;
    d.idx = '0;
    d.target = addr_map_pkg::tgt_mem;
    d.err = 1'b0;
    // Direct C0-CF is folded into working addressing here
    working = (m == addr_map_pkg::mode_working) ||
      ((m == addr_map_pkg::mode_direct) &&
       (a[7:4] == addr_map_pkg::WORKING_NIBBLE));
    eff = a;
    if (working)
    begin
      eff = a[3] ? {spb[7:addr_map_pkg::SLICE_LSB], a[2:0]}
                 : {spa[7:addr_map_pkg::SLICE_LSB], a[2:0]};
    end
    if (eff < addr_map_pkg::SET1_FIRST)
    begin
      d.idx = {1'b0, page[0], eff};
      d.err = (page >= addr_map_pkg::PAGE_COUNT);
    end
    else if (m == addr_map_pkg::mode_indirect)
    begin
      d.idx = {addr_map_pkg::REGION_SET2, 1'b0, page[0],
               eff[5:0]};
      d.err = (page >= addr_map_pkg::PAGE_COUNT);
    end
    else
    begin
      // Working accesses above C0 stay in set 1, bank 0
      bank_bit = (eff >= addr_map_pkg::BANKED_FIRST) && !working &&
        bank;
      d.idx = {addr_map_pkg::REGION_SET1, 1'b0, bank_bit,
               eff[5:0]};
      d.target = (eff == addr_map_pkg::SLICE_A_ADDR) ?
        addr_map_pkg::tgt_slice_a : (eff == addr_map_pkg::SLICE_B_ADDR) ?
        addr_map_pkg::tgt_slice_b : (eff == addr_map_pkg::PAGE_SELECT_ADDR) ?
        addr_map_pkg::tgt_page : addr_map_pkg::tgt_mem;
    end
    return d;
  endfunction

  function automatic logic [7:0] read_byte(
    input addr_map_pkg::decode_t d
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (d.target)
      addr_map_pkg::tgt_mem: v = reg_mem[d.idx];
      addr_map_pkg::tgt_slice_a: v = state.slice_a;
      addr_map_pkg::tgt_slice_b: v = state.slice_b;
      addr_map_pkg::tgt_page: v = state.page_sel;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  logic [3:0] src_page;
  logic [3:0] dst_page;
  logic [7:0] addr_hi;
  logic [7:0] addr_lo;
  addr_map_pkg::decode_t rd_hi;
  addr_map_pkg::decode_t rd_lo;
  addr_map_pkg::decode_t wr_hi;
  addr_map_pkg::decode_t wr_lo;
  logic rd_err;
  logic wr_err;
  logic wr_hi_mem;
  logic wr_lo_mem;

  always_comb
  begin
    src_page = state.page_sel[addr_map_pkg::PAGE_SRC_LSB +: 4];
    dst_page = state.page_sel[addr_map_pkg::PAGE_DST_LSB +: 4];
    addr_hi = {reg_addr[7:1], 1'b0};
    addr_lo = reg_pair ? {reg_addr[7:1], 1'b1} : reg_addr;
    rd_hi = decode_reg(addr_hi, reg_mode, src_page, state.bank,
      state.slice_a, state.slice_b);
    rd_lo = decode_reg(addr_lo, reg_mode, src_page, state.bank,
      state.slice_a, state.slice_b);
    wr_hi = decode_reg(addr_hi, reg_mode, dst_page, state.bank,
      state.slice_a, state.slice_b);
    wr_lo = decode_reg(addr_lo, reg_mode, dst_page, state.bank,
      state.slice_a, state.slice_b);
    rd_err = rd_lo.err || (reg_pair && rd_hi.err);
    wr_err = wr_lo.err || (reg_pair && wr_hi.err);
    wr_hi_mem = reg_wr && reg_pair && !wr_err &&
      (wr_hi.target == addr_map_pkg::tgt_mem);
    wr_lo_mem = reg_wr && !wr_err &&
      (wr_lo.target == addr_map_pkg::tgt_mem);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic in_rom;
  logic in_option;
  logic [1:0] opt_sel;
  logic [1:0] load_sel;

  always_comb
  begin
    next_state = state;
    in_rom = (state.pc <= addr_map_pkg::ROM_LAST);
    in_option = (state.pc >= addr_map_pkg::OPTION_FIRST) &&
      (state.pc <= addr_map_pkg::OPTION_LAST);
    opt_sel = state.pc[1:0];
    load_sel = rom_load_addr[1:0];

    // Program side
    next_state.prog_rvalid = 1'b0;
    if (pc_load)
    begin
      next_state.pc = pc_load_addr;
    end
    else if (fetch_en)
    begin
      next_state.prog_rvalid = 1'b1;
      next_state.prog_vector = (state.pc <= addr_map_pkg::VECTOR_LAST);
      next_state.prog_option = in_option;
      next_state.prog_range_err = !in_rom;
      next_state.prog_rdata = !in_rom ? addr_map_pkg::ERASED_BYTE :
        in_option ? state.option_bytes[opt_sel*8 +: 8] :
        rom_mem[state.pc[addr_map_pkg::ROM_ADDR_W-1:0]];
      next_state.pc = state.pc + 16'h0001;
    end
    if (rom_load_en && (rom_load_addr >= addr_map_pkg::OPTION_FIRST) &&
        (rom_load_addr <= addr_map_pkg::OPTION_LAST))
    begin
      next_state.option_bytes[load_sel*8 +: 8] = rom_load_data;
    end

    // Register reads: single byte sits in the low half
    next_state.reg_rvalid = reg_rd;
    next_state.reg_access_err = (reg_rd && rd_err) || (reg_wr && wr_err);
    if (reg_rd)
    begin
      next_state.reg_rdata = rd_err ? 16'h0000 :
        {reg_pair ? read_byte(rd_hi) : 8'h00, read_byte(rd_lo)};
    end

    // Register writes to the slice pointer and page select registers
    if (reg_wr && !wr_err)
    begin
      if (reg_pair)
      begin
        unique case (wr_hi.target)
          addr_map_pkg::tgt_slice_a: next_state.slice_a = reg_wdata[15:8];
          addr_map_pkg::tgt_slice_b: next_state.slice_b = reg_wdata[15:8];
          addr_map_pkg::tgt_page: next_state.page_sel = reg_wdata[15:8];
          addr_map_pkg::tgt_mem: ;
        endcase
      end
      unique case (wr_lo.target)
        addr_map_pkg::tgt_slice_a: next_state.slice_a = reg_wdata[7:0];
        addr_map_pkg::tgt_slice_b: next_state.slice_b = reg_wdata[7:0];
        addr_map_pkg::tgt_page: next_state.page_sel = reg_wdata[7:0];
        addr_map_pkg::tgt_mem: ;
      endcase
    end

    // Set-pointer instructions override a load in the same cycle
    if (set_both_slice_pointers_instr)
    begin
      next_state.slice_a = {slice_operand[7:4], 4'h0};
      next_state.slice_b = {slice_operand[7:4],
        addr_map_pkg::SECOND_SLICE_LOW};
    end
    else
    begin
      if (set_first_slice_pointer_instr)
      begin
        next_state.slice_a = slice_operand;
      end
      if (set_second_slice_pointer_instr)
      begin
        next_state.slice_b = slice_operand;
      end
    end

    // Bank flag moves only on its own instructions; bank one wins if both
    if (select_bank_one_instr || select_bank_zero_instr)
    begin
      next_state.bank = select_bank_one_instr;
    end
  end

  // ---------------------------------------------------------------
  // Registers and storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= STATE_RESET;
    end
    else if (ce)
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst && ce)
    begin
      if (rom_load_en && (rom_load_addr <= addr_map_pkg::ROM_LAST))
      begin
        rom_mem[rom_load_addr[addr_map_pkg::ROM_ADDR_W-1:0]] <=
          rom_load_data;
      end
      if (wr_hi_mem)
      begin
        reg_mem[wr_hi.idx] <= reg_wdata[15:8];
      end
      if (wr_lo_mem)
      begin
        reg_mem[wr_lo.idx] <= reg_wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prog_addr = state.pc;
  assign prog_rdata = state.prog_rdata;
  assign prog_rvalid = state.prog_rvalid;
  assign prog_vector_area = state.prog_vector;
  assign prog_option_area = state.prog_option;
  assign prog_range_err = state.prog_range_err;
  assign reg_rdata = state.reg_rdata;
  assign reg_rvalid = state.reg_rvalid;
  assign reg_access_err = state.reg_access_err;
  assign working_slice_pointer_a = state.slice_a;
  assign working_slice_pointer_b = state.slice_b;
  assign register_page_select = state.page_sel;
  assign bank_select = state.bank;

endmodule

// *** testbench/register_file_address_map_chk.sv ***
// Port-level assertions for the address decoder
module register_file_address_map_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic fetch_en,
  input wire logic pc_load,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire addr_map_pkg::addr_mode_t reg_mode,
  input wire logic select_bank_zero_instr,
  input wire logic select_bank_one_instr,
  input wire logic set_both_slice_pointers_instr,
  input wire logic set_first_slice_pointer_instr,
  input wire logic set_second_slice_pointer_instr,
  input wire logic [7:0] slice_operand,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_rvalid,
  input wire logic prog_vector_area,
  input wire logic prog_range_err,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_access_err,
  input wire logic [7:0] working_slice_pointer_a,
  input wire logic [7:0] working_slice_pointer_b,
  input wire logic [7:0] register_page_select,
  input wire logic bank_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  AST_RESET: assert property (disable iff (1'b0) rst |=>
    prog_addr == 16'h0100 && working_slice_pointer_a == 8'hC0 &&
    working_slice_pointer_b == 8'hC8 && register_page_select == 8'h00)
    else $error("reset state wrong");
  AST_RVALID: assert property (reg_rd && ce |=> reg_rvalid)
    else $error("read not answered");
  AST_BOTH: assert property (set_both_slice_pointers_instr && ce |=>
    working_slice_pointer_a == {$past(slice_operand[7:4]), 4'h0} &&
    working_slice_pointer_b == {$past(slice_operand[7:4]), 4'h8})
    else $error("combined pointer set wrong");
  AST_SECOND: assert property (set_second_slice_pointer_instr && ce &&
    !set_both_slice_pointers_instr && !set_first_slice_pointer_instr &&
    !reg_wr |=> $stable(working_slice_pointer_a))
    else $error("second pointer set touched first");
  AST_BANK1: assert property (select_bank_one_instr && ce |=> bank_select)
    else $error("bank one not selected");
  AST_HOLD: assert property (!select_bank_zero_instr &&
    !select_bank_one_instr |=> $stable(bank_select))
    else $error("bank flag changed by itself");
  AST_FETCH: assert property (fetch_en && !pc_load && ce |=>
    prog_rvalid && prog_addr == $past(prog_addr) + 16'h0001)
    else $error("fetch did not advance");
  AST_VECTOR: assert property (fetch_en && !pc_load && ce |=>
    prog_vector_area == ($past(prog_addr) <= 16'h00FF))
    else $error("vector area flag wrong");
  AST_RANGE: assert property (fetch_en && !pc_load && ce &&
    prog_addr > 16'h3FFF |=> prog_range_err && prog_rdata == 8'hFF)
    else $error("out of range fetch not flagged");
  AST_PAGE: assert property (reg_rd && ce && reg_addr < 8'hC0 &&
    reg_mode == addr_map_pkg::mode_indirect &&
    register_page_select[3:0] > 4'h1 |=> reg_access_err && reg_rdata == '0)
    else $error("bad page not refused");
endmodule
bind register_file_address_map register_file_address_map_chk chk_i (.*);

// *** testbench/cpu_core_model.sv ***
// CPU-side model issuing register, instruction and fetch cycles
module cpu_core_model (
  input wire logic clk,
  output logic ce,
  output logic fetch_en,
  output logic pc_load,
  output logic [15:0] pc_load_addr,
  output logic rom_load_en,
  output logic [15:0] rom_load_addr,
  output logic [7:0] rom_load_data,
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_pair,
  output logic [7:0] reg_addr,
  output addr_map_pkg::addr_mode_t reg_mode,
  output logic [15:0] reg_wdata,
  output logic select_bank_zero_instr,
  output logic select_bank_one_instr,
  output logic set_both_slice_pointers_instr,
  output logic set_first_slice_pointer_instr,
  output logic set_second_slice_pointer_instr,
  output logic [7:0] slice_operand
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulse order: bank 0, bank 1, both, first, second
  logic [4:0] ins_q;
  assign {select_bank_zero_instr, select_bank_one_instr,
    set_both_slice_pointers_instr, set_first_slice_pointer_instr,
    set_second_slice_pointer_instr} = ins_q;
  initial
  begin
    ce = 1'b1;
    {fetch_en, pc_load, rom_load_en, reg_rd, reg_wr, reg_pair} = '0;
    {pc_load_addr, rom_load_addr, rom_load_data, reg_addr} = '0;
    reg_mode = addr_map_pkg::mode_direct;
    reg_wdata = 16'h0000;
    ins_q = 5'h00;
    slice_operand = 8'h00;
  end
  // Held across the taking edge; a released bus shows the inverse
  task automatic acc(input logic rd, input logic wr, input logic pr,
    input logic [7:0] a, input addr_map_pkg::addr_mode_t m,
    input logic [15:0] d);
    @(negedge clk);
    {reg_rd, reg_wr, reg_pair} = {rd, wr, pr};
    reg_addr = a;
    reg_mode = m;
    reg_wdata = d;
    @(negedge clk);
    {reg_rd, reg_wr} = 2'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic ins(input logic [4:0] p, input logic [7:0] op);
    @(negedge clk);
    ins_q = p;
    slice_operand = op;
    @(negedge clk);
    ins_q = 5'h00;
    slice_operand = ~op;
  endtask
  task automatic rom(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {rom_load_en, rom_load_addr, rom_load_data} = {1'b1, a, d};
    @(negedge clk);
    rom_load_en = 1'b0;
  endtask
  task automatic fetch(input logic ld, input logic [15:0] a);
    @(negedge clk);
    {pc_load, pc_load_addr, fetch_en} = {ld, a, !ld};
    if (ld)
    begin
      @(negedge clk);
      {pc_load, fetch_en} = 2'b01;
    end
    @(negedge clk);
    fetch_en = 1'b0;
  endtask
endmodule

// *** testbench/register_file_address_map_bench.sv ***
// Self-checking bench for the address decoder
module register_file_address_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, fetch_en, pc_load, rom_load_en, reg_rd, reg_wr;
  logic reg_pair, select_bank_zero_instr, select_bank_one_instr;
  logic set_both_slice_pointers_instr, set_first_slice_pointer_instr;
  logic set_second_slice_pointer_instr, prog_rvalid, prog_vector_area;
  logic prog_option_area, prog_range_err, reg_rvalid, reg_access_err;
  logic bank_select;
  logic [7:0] reg_addr, rom_load_data, slice_operand, prog_rdata;
  logic [7:0] working_slice_pointer_a, working_slice_pointer_b;
  logic [7:0] register_page_select;
  logic [15:0] pc_load_addr, rom_load_addr, reg_wdata, prog_addr;
  logic [15:0] reg_rdata;
  addr_map_pkg::addr_mode_t reg_mode;
  localparam addr_map_pkg::addr_mode_t m_dir = addr_map_pkg::mode_direct;
  localparam addr_map_pkg::addr_mode_t m_ind = addr_map_pkg::mode_indirect;
  localparam addr_map_pkg::addr_mode_t m_wrk = addr_map_pkg::mode_working;
  int fail_count = 0;
  int tests_run = 0;
  register_file_address_map dut (.*);
  cpu_core_model cpu (.*);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input addr_map_pkg::addr_mode_t m,
    input logic [15:0] e);
    cpu.acc(1'b1, 1'b0, 1'b0, a, m, 16'h0000);
    chk(reg_rdata, e);
    chk(reg_rvalid, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input addr_map_pkg::addr_mode_t m,
    input logic [15:0] d);
    cpu.acc(1'b0, 1'b1, 1'b0, a, m, d);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whole sequence needs about 0.4 us; ten times that means a hang
  initial
  begin
    #4000;
    fail_count++;
    stop_test();
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(prog_addr, 16'h0100);
    chk({working_slice_pointer_a, working_slice_pointer_b}, 16'hC0C8);
    chk({register_page_select, 7'h00, bank_select}, 16'h0000);
    rdc(8'hDF, m_dir, 16'h0000);
    cpu.ins(5'b00100, 8'h7F);
    chk({working_slice_pointer_a, working_slice_pointer_b}, 16'h7078);
    cpu.ins(5'b00001, 8'h48);
    cpu.ins(5'b00010, 8'hA0);
    chk({working_slice_pointer_a, working_slice_pointer_b}, 16'hA048);
    // A low clock enable must swallow an instruction
    cpu.ce = 1'b0;
    cpu.ins(5'b00100, 8'h30);
    cpu.ce = 1'b1;
    chk({working_slice_pointer_a, working_slice_pointer_b}, 16'hA048);
    wr(8'hD6, m_dir, 16'h0070);
    chk(working_slice_pointer_a, 8'h70);
    rdc(8'hD7, m_dir, 16'h0048);
    wr(8'h06, m_wrk, 16'h005A);
    rdc(8'h76, m_dir, 16'h005A);
    rdc(8'hC6, m_dir, 16'h005A);
    wr(8'h0E, m_wrk, 16'h003C);
    rdc(8'h4E, m_dir, 16'h003C);
    cpu.acc(1'b0, 1'b1, 1'b1, 8'h51, m_dir, 16'h1234);
    rdc(8'h50, m_dir, 16'h0012);
    rdc(8'h51, m_dir, 16'h0034);
    cpu.acc(1'b1, 1'b0, 1'b1, 8'h50, m_dir, 16'h0000);
    chk(reg_rdata, 16'h1234);
    wr(8'hE5, m_dir, 16'h0011);
    wr(8'hE5, m_ind, 16'h0022);
    cpu.ins(5'b01000, 8'h00);
    wr(8'hD0, m_dir, 16'h0066);
    wr(8'hE5, m_dir, 16'h0033);
    rdc(8'hE5, m_dir, 16'h0033);
    rdc(8'hE5, m_ind, 16'h0022);
    cpu.ins(5'b00010, 8'hE0);
    rdc(8'h05, m_wrk, 16'h0011);
    cpu.ins(5'b10000, 8'h00);
    rdc(8'hD0, m_dir, 16'h0066);
    rdc(8'hE5, m_dir, 16'h0011);
    wr(8'h40, m_ind, 16'h00AA);
    wr(8'hDF, m_dir, 16'h0011);
    wr(8'h40, m_ind, 16'h00BB);
    wr(8'hE5, m_ind, 16'h0044);
    rdc(8'h40, m_ind, 16'h00BB);
    rdc(8'hE5, m_dir, 16'h0011);
    wr(8'hDF, m_dir, 16'h0010);
    chk(register_page_select, 8'h10);
    rdc(8'h40, m_ind, 16'h00AA);
    wr(8'hDF, m_dir, 16'h0000);
    rdc(8'hE5, m_ind, 16'h0022);
    wr(8'hDF, m_dir, 16'h0022);
    rdc(8'h40, m_ind, 16'h0000);
    chk(reg_access_err, 1'b1);
    cpu.rom(16'h0100, 8'h5A);
    cpu.rom(16'h0010, 8'h77);
    cpu.rom(16'h3FFF, 8'hC3);
    cpu.fetch(1'b0, 16'h0000);
    chk({prog_rdata, prog_addr[7:0]}, 16'h5A01);
    chk(prog_rvalid, 1'b1);
    cpu.fetch(1'b1, 16'h0010);
    chk({prog_rdata, 7'h00, prog_vector_area}, 16'h7701);
    cpu.fetch(1'b1, 16'h003C);
    chk({prog_rdata, 7'h00, prog_option_area}, 16'hFF01);
    cpu.fetch(1'b1, 16'h3FFF);
    chk({prog_rdata, 7'h00, prog_range_err}, 16'hC300);
    cpu.fetch(1'b0, 16'h0000);
    chk({prog_rdata, 7'h00, prog_range_err}, 16'hFF01);
    stop_test();
  end
endmodule
